/* core/rsc_top.sv */
// reset source control: gathers power-on, brownout, bad level code, flash key
// and watchdog resets, records brownout and bad level code in the cause register and watchdog in the status flags, and holds the core in reset
// assumes an AXI4-Lite master on aclk; aresetn is the power-on reset
//
// Overview of operation
// - power-on reset clears the program counter, so fetch starts at address zero.
// - power-on reset sets all port data and direction registers to ones.
// - a qualified brownout performs a full device reset.
// - brownout detector always on in fast or slow mode, no enable.
// - brownout detector switched off automatically in sleep or idle.
// - low supply must persist beyond the filter time to cause reset.
// - brownout reset sets brownout flag and keeps the level register.
// - six level codes are valid, all meaning the fixed threshold.
// - undefined level code: full reset after delay, register restored to power-on value.
// - level register loads 0x66 at power-on.
// - bad level code sets cause bit 1; only software or power-on clears it.
// - brownout sets cause bit 2; only software writing zero or power-on clears it.
// - cause register bits 7 to 3 read as zero.
// - writing 0x55 to the first flash control register resets the device.
// - watchdog time-out in normal mode resets device and sets timeout flag.
// - watchdog time-out asleep clears only counter and stack, sets both flags.
// - power-on clears timeout and power-down flags; brownout leaves them.
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"

module rsc_top
    import rsc_pkg::*;
#(
    parameter int FILTER_CYCLES = (`RSC_FILTER_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS,
    parameter int SRESET_CYCLES = (`RSC_SRESET_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS,
    parameter int SETTLE_CYCLES = (`RSC_SETTLE_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS
)
(
    // clock and power-on reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // reset sources
    input wire logic low_supply,
    input wire logic low_power_mode,
    input wire logic watchdog_timeout,
    // reset outputs to the core
    output logic core_reset,
    output logic pc_sp_clear,
    output logic port_preset,
    output logic [7:0] port_reset_value
);

    logic brown_qual;
    logic bad_level;
    logic bad_fire;
    logic [7:0] level_code;
    logic [2:0] cause;
    logic timeout_status_flag;
    logic power_down_flag;
    logic flash_key_hit;
    logic full_req;
    logic [31:0] settle_count;
    logic first_after_por;
    rsc_state_t state;
    rsc_src_t pending_src;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // ----------------------------------------
    // reset sources
    // ----------------------------------------
    // detector is only armed outside sleep or idle
    rsc_filter #(.FILTER_CYCLES(FILTER_CYCLES)) u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(!low_power_mode && state == RSC_RUN),
        .low_supply(low_supply),
        .qualified(brown_qual)
    );

    assign bad_level = !rsc_level_valid(level_code);

    rsc_delay #(.DELAY_CYCLES(SRESET_CYCLES)) u_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(bad_level && state == RSC_RUN),
        .fire(bad_fire)
    );

    assign full_req = brown_qual || bad_fire || flash_key_hit ||
                      (watchdog_timeout && !low_power_mode);

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr > `RSC_OFF_CONTROL || aw_addr[1:0] != 2'b00) ? 2'b10 : 2'b00;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `RSC_OFF_LEVEL: s_axi_rdata <= {24'h0, level_code};
                `RSC_OFF_CAUSE: s_axi_rdata <= {29'h0, cause};
                `RSC_OFF_FLASH: s_axi_rdata <= 32'h0;
                `RSC_OFF_STATUS: s_axi_rdata <= {30'h0, power_down_flag, timeout_status_flag};
                `RSC_OFF_CONTROL: s_axi_rdata <= 32'h0;
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // brownout level register
    // ----------------------------------------
    // a brownout keeps the code; only a bad code or power-on restores it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            level_code <= `RSC_LEVEL_POR;
        end
        else if (bad_fire)
        begin
            level_code <= `RSC_LEVEL_POR;
        end
        else if (do_write && aw_addr == `RSC_OFF_LEVEL && w_strb[0])
        begin
            level_code <= w_data[7:0];
        end
    end

    assign flash_key_hit = do_write && aw_addr == `RSC_OFF_FLASH && w_strb[0] &&
                           w_data[7:0] == `RSC_FLASH_KEY;

    // ----------------------------------------
    // reset cause register
    // ----------------------------------------
    // hardware set beats a software clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cause <= 3'b000;
        end
        else
        begin
            if (do_write && aw_addr == `RSC_OFF_CAUSE && w_strb[0])
            begin
                cause <= cause & w_data[2:0];
            end
            if (bad_fire)
            begin
                cause[`RSC_CAUSE_BADLVL] <= 1'b1;
            end
            if (brown_qual)
            begin
                cause[`RSC_CAUSE_BROWN] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // halt and clear-watchdog stand in for the core's instructions
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            timeout_status_flag <= 1'b0;
            power_down_flag <= 1'b0;
        end
        else if (watchdog_timeout && state == RSC_RUN)
        begin
            timeout_status_flag <= 1'b1;
            if (low_power_mode)
            begin
                power_down_flag <= 1'b1;
            end
        end
        else if (do_write && aw_addr == `RSC_OFF_CONTROL && w_strb[0])
        begin
            if (w_data[`RSC_CTL_CLRWDT])
            begin
                timeout_status_flag <= 1'b0;
                power_down_flag <= 1'b0;
            end
            else if (w_data[`RSC_CTL_HALT])
            begin
                power_down_flag <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // reset sequencer
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= RSC_HOLD;
            pending_src <= RSC_SRC_NONE;
            settle_count <= 32'h0;
            first_after_por <= 1'b1;
        end
        else
        begin
            case (state)
                RSC_RUN:
                begin
                    first_after_por <= 1'b0;
                    if (full_req)
                    begin
                        state <= RSC_HOLD;
                        pending_src <= brown_qual ? RSC_SRC_BROWN : RSC_SRC_SOFT;
                    end
                    else if (watchdog_timeout && low_power_mode)
                    begin
                        pending_src <= RSC_SRC_WDOG;
                    end
                    else
                    begin
                        pending_src <= RSC_SRC_NONE;
                    end
                end
                RSC_HOLD:
                begin
                    settle_count <= 32'h0;
                    if (!low_supply || low_power_mode)
                    begin
                        state <= RSC_WAIT;
                    end
                end
                RSC_WAIT:
                begin
                    if (low_supply && !low_power_mode)
                    begin
                        state <= RSC_HOLD;
                    end
                    else if (settle_count >= 32'(SETTLE_CYCLES - 1))
                    begin
                        state <= RSC_RUN;
                    end
                    else
                    begin
                        settle_count <= settle_count + 32'h1;
                    end
                end
                default:
                begin
                    state <= RSC_HOLD;
                end
            endcase
        end
    end

    // ----------------------------------------
    // reset outputs
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_reset <= 1'b1;
            pc_sp_clear <= 1'b1;
            port_preset <= 1'b1;
            port_reset_value <= `RSC_PORT_POR;
        end
        else
        begin
            core_reset <= state != RSC_RUN;
            pc_sp_clear <= state != RSC_RUN || pending_src == RSC_SRC_WDOG;
            port_preset <= state != RSC_RUN && first_after_por;
            port_reset_value <= `RSC_PORT_POR;
        end
    end

endmodule // rsc_top

`default_nettype wire

/* core/rsc_defs.svh */
// constants of the reset source control block: offsets, reset values, codes, timings
// assumes inclusion by bare name from the package and the modules
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RSC_OFF_LEVEL     12'h000
`define RSC_OFF_CAUSE     12'h004
`define RSC_OFF_FLASH     12'h008
`define RSC_OFF_STATUS    12'h00C
`define RSC_OFF_CONTROL   12'h010

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RSC_LEVEL_POR     8'h66
`define RSC_LEVEL_OK1     8'h55
`define RSC_LEVEL_OK2     8'h33
`define RSC_LEVEL_OK3     8'h99
`define RSC_LEVEL_OK4     8'hAA
`define RSC_LEVEL_OK5     8'hF0
`define RSC_FLASH_KEY     8'h55
`define RSC_PORT_POR      8'hFF

// ----------------------------------------
// field positions
// ----------------------------------------
`define RSC_CAUSE_WDOG    0
`define RSC_CAUSE_BADLVL  1
`define RSC_CAUSE_BROWN   2
`define RSC_STAT_TO       0
`define RSC_STAT_PDF      1
`define RSC_CTL_HALT      0
`define RSC_CTL_CLRWDT    1

// ----------------------------------------
// timing, in ns
// ----------------------------------------
`define RSC_CLK_NS        8
`define RSC_FILTER_NS     120000
`define RSC_SRESET_NS     16000
`define RSC_SETTLE_NS     8000

`endif

/* core/rsc_pkg.sv */
// types shared by the reset source control block
// assumes rsc_defs.svh on the include path
`include "rsc_defs.svh"

package rsc_pkg;

    typedef enum logic [1:0] {
        RSC_RUN   = 2'b00,
        RSC_HOLD  = 2'b01,
        RSC_WAIT  = 2'b10
    } rsc_state_t;

    typedef enum logic [1:0] {
        RSC_SRC_NONE  = 2'b00,
        RSC_SRC_BROWN = 2'b01,
        RSC_SRC_SOFT  = 2'b10,
        RSC_SRC_WDOG  = 2'b11
    } rsc_src_t;

    function automatic logic rsc_level_valid(input logic [7:0] code);
        rsc_level_valid = (code == `RSC_LEVEL_POR) || (code == `RSC_LEVEL_OK1) ||
                          (code == `RSC_LEVEL_OK2) || (code == `RSC_LEVEL_OK3) ||
                          (code == `RSC_LEVEL_OK4) || (code == `RSC_LEVEL_OK5);
    endfunction

endpackage

/* core/rsc_filter.sv */
// brownout duration filter: qualifies a low supply level held long enough
// assumes low_supply synchronous to aclk
`timescale 1ns/1ps
`default_nettype none

module rsc_filter
    import rsc_pkg::*;
#(
    parameter int FILTER_CYCLES = 15000
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // detector
    input wire logic enable,
    input wire logic low_supply,
    output logic qualified
);

    logic [31:0] count;

    // ----------------------------------------
    // persistence counter
    // ----------------------------------------
    // any gap in the low indication restarts the count, so glitches never reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enable || !low_supply)
        begin
            count <= 32'h0;
            qualified <= 1'b0;
        end
        else if (count < 32'(FILTER_CYCLES))
        begin
            count <= count + 32'h1;
            qualified <= 1'b0;
        end
        else
        begin
            qualified <= 1'b1;
        end
    end

endmodule // rsc_filter

`default_nettype wire

/* core/rsc_delay.sv */
// one-shot delay: fires a pulse a fixed number of cycles after start
// assumes start is a level that may stay high
`timescale 1ns/1ps
`default_nettype none

module rsc_delay
    import rsc_pkg::*;
#(
    parameter int DELAY_CYCLES = 2000
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic start,
    output logic fire
);

    logic [31:0] count;
    logic busy;

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !start)
        begin
            count <= 32'h0;
            busy <= 1'b0;
            fire <= 1'b0;
        end
        else if (!busy)
        begin
            if (count >= 32'(DELAY_CYCLES - 1))
            begin
                fire <= 1'b1;
                busy <= 1'b1;
            end
            else
            begin
                count <= count + 32'h1;
            end
        end
        else
        begin
            fire <= 1'b0;
        end
    end

endmodule // rsc_delay

`default_nettype wire

/* sim/rsc_top_sva.sv */
// checker of rsc_top reset sequencing, bound onto the top module
// assumes one clock aclk and the synchronous reset aresetn
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"

module rsc_top_sva #(
    parameter int FILTER_CYCLES = 8,
    parameter int SETTLE_CYCLES = 4
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus write side
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    // sources
    input wire logic low_supply,
    input wire logic low_power_mode,
    input wire logic watchdog_timeout,
    // core side
    input wire logic core_reset,
    input wire logic pc_sp_clear,
    input wire logic port_preset,
    input wire logic [7:0] port_reset_value
);
    logic [15:0] lo_cnt;
    logic [15:0] rs_cnt;
    logic key_wr;
    logic wd_lp;

    assign key_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
        && s_axi_awaddr == `RSC_OFF_FLASH && s_axi_wdata[7:0] == `RSC_FLASH_KEY;
    assign wd_lp = watchdog_timeout && low_power_mode && !core_reset;

    // run lengths of low supply and of held core reset
    always_ff @(posedge aclk)
    begin
        lo_cnt <= (!aresetn || !low_supply || low_power_mode) ? 16'h0000 : lo_cnt + 16'h0001;
        rs_cnt <= (!aresetn || !core_reset) ? 16'h0000 : rs_cnt + 16'h0001;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_fill;
        port_reset_value == `RSC_PORT_POR;
    endproperty
    a_fill: assert property (p_fill) else $error("port value not all ones");

    property p_por;
        $rose(aresetn) |-> core_reset && pc_sp_clear && port_preset;
    endproperty
    a_por: assert property (p_por) else $error("power-on outputs wrong");

    property p_pc;
        core_reset |-> pc_sp_clear;
    endproperty
    a_pc: assert property (p_pc) else $error("counter not cleared in reset");

    property p_pre;
        port_preset |-> core_reset;
    endproperty
    a_pre: assert property (p_pre) else $error("port preset outside reset");

    property p_wdn;
        watchdog_timeout && !low_power_mode && !core_reset |-> ##[1:3] core_reset;
    endproperty
    a_wdn: assert property (p_wdn) else $error("watchdog reset missing");

    property p_wds;
        wd_lp |=> !core_reset [*6];
    endproperty
    a_wds: assert property (p_wds) else $error("full reset in low power");

    property p_wdc;
        wd_lp |-> ##[1:4] pc_sp_clear;
    endproperty
    a_wdc: assert property (p_wdc) else $error("no counter clear in low power");

    property p_bro;
        lo_cnt == 16'(FILTER_CYCLES + 2) |-> ##[0:3] core_reset;
    endproperty
    a_bro: assert property (p_bro) else $error("brownout reset missing");

    property p_key;
        key_wr |-> ##[1:5] core_reset;
    endproperty
    a_key: assert property (p_key) else $error("flash key reset missing");

    property p_set;
        $fell(core_reset) |-> rs_cnt >= 16'(SETTLE_CYCLES);
    endproperty
    a_set: assert property (p_set) else $error("core released too early");

    c_bro: cover property ($rose(core_reset) && low_supply);
    c_key: cover property (key_wr);
    c_wds: cover property (wd_lp);
endmodule // rsc_top_sva

bind rsc_top rsc_top_sva #(.FILTER_CYCLES(FILTER_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .low_supply(low_supply),
    .low_power_mode(low_power_mode), .watchdog_timeout(watchdog_timeout), .core_reset(core_reset),
    .pc_sp_clear(pc_sp_clear), .port_preset(port_preset), .port_reset_value(port_reset_value));

`default_nettype wire

/* sim/rsc_top_bench.sv */
// self-checking bench of rsc_top: bus tasks and reset scenarios
// assumes the design and checker compiled first; short counts keep the run brief
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"

module rsc_top_bench;
    localparam int FC = 8;
    localparam int SR = 4;
    localparam int ST = 4;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic low_supply = 1'b0, low_power_mode = 1'b0, watchdog_timeout = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rresp_seen, bresp_seen;
    logic [31:0] s_axi_rdata;
    logic core_reset, pc_sp_clear, port_preset;
    logic clr_seen = 1'b0;
    logic [7:0] port_reset_value;
    logic [7:0] codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
    int fail_count = 0;
    int checks = 0;

    rsc_top #(.FILTER_CYCLES(FC), .SRESET_CYCLES(SR), .SETTLE_CYCLES(ST)) uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .low_supply, .low_power_mode, .watchdog_timeout, .core_reset, .pc_sp_clear, .port_preset,
        .port_reset_value);

    always #4 aclk = ~aclk;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        bresp_seen = s_axi_bresp;
    endtask

    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rresp_seen = s_axi_rresp;
        check(n, s_axi_rdata, e);
    endtask

    task automatic wait_core(input logic v);
        int n;
        n = 0;
        while (core_reset !== v && n < 4000)
        begin
            @(posedge aclk);
            n++;
        end
        check("core_reset", {31'h0, core_reset}, {31'h0, v});
    endtask

    // a reset that comes and goes inside the span is still caught
    task automatic quiet(input int c);
        logic hit;
        hit = 1'b0;
        clr_seen = 1'b0;
        repeat (c)
        begin
            @(posedge aclk);
            hit = hit | core_reset;
            clr_seen = clr_seen | pc_sp_clear;
        end
        check("core quiet", {31'h0, hit}, 32'h0);
    endtask

    task automatic tend(input string n);
        $display("test %s done", n);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        wait_core(1'b0);
        check("port value", {24'h0, port_reset_value}, 32'hFF);
        rd_chk("level", `RSC_OFF_LEVEL, 32'h66);
        rd_chk("cause", `RSC_OFF_CAUSE, 32'h0);
        rd_chk("status", `RSC_OFF_STATUS, 32'h0);
        rd_chk("unmapped", 12'h020, 32'h0);
        check("rresp", {30'h0, rresp_seen}, 32'h2);
        wr(12'h014, 8'h00);
        check("bresp unmapped", {30'h0, bresp_seen}, 32'h2);
        tend("power_on");
        wr(`RSC_OFF_LEVEL, 8'h55);
        check("bresp", {30'h0, bresp_seen}, 32'h0);
        wr(`RSC_OFF_CONTROL, 8'h01);
        @(posedge aclk);
        low_supply <= 1'b1;
        repeat (FC - 2) @(posedge aclk);
        low_supply <= 1'b0;
        quiet(20);
        check("pc clear idle", {31'h0, clr_seen}, 32'h0);
        low_supply <= 1'b1;
        wait_core(1'b1);
        low_supply <= 1'b0;
        wait_core(1'b0);
        rd_chk("level kept", `RSC_OFF_LEVEL, 32'h55);
        rd_chk("cause brown", `RSC_OFF_CAUSE, 32'h4);
        rd_chk("status kept", `RSC_OFF_STATUS, 32'h2);
        wr(`RSC_OFF_STATUS, 8'h00);
        rd_chk("status ro", `RSC_OFF_STATUS, 32'h2);
        wr(`RSC_OFF_CAUSE, 8'hF8);
        rd_chk("cause clear", `RSC_OFF_CAUSE, 32'h0);
        tend("brownout");
        foreach (codes[i])
        begin
            wr(`RSC_OFF_LEVEL, codes[i]);
            quiet(SR + 8);
            rd_chk("level code", `RSC_OFF_LEVEL, {24'h0, codes[i]});
        end
        wr(`RSC_OFF_LEVEL, 8'h12);
        wait_core(1'b1);
        wait_core(1'b0);
        rd_chk("level restored", `RSC_OFF_LEVEL, 32'h66);
        rd_chk("cause bad code", `RSC_OFF_CAUSE, 32'h2);
        tend("level_codes");
        wr(`RSC_OFF_FLASH, 8'h54);
        quiet(8);
        wr(`RSC_OFF_FLASH, 8'h55);
        wait_core(1'b1);
        wait_core(1'b0);
        rd_chk("flash reads", `RSC_OFF_FLASH, 32'h0);
        rd_chk("cause kept", `RSC_OFF_CAUSE, 32'h2);
        tend("flash_key");
        wr(`RSC_OFF_CONTROL, 8'h02);
        @(posedge aclk);
        watchdog_timeout <= 1'b1;
        @(posedge aclk);
        watchdog_timeout <= 1'b0;
        wait_core(1'b1);
        wait_core(1'b0);
        rd_chk("status wdog", `RSC_OFF_STATUS, 32'h1);
        wr(`RSC_OFF_CONTROL, 8'h02);
        low_power_mode <= 1'b1;
        low_supply <= 1'b1;
        quiet(FC + 8);
        low_supply <= 1'b0;
        watchdog_timeout <= 1'b1;
        @(posedge aclk);
        watchdog_timeout <= 1'b0;
        quiet(8);
        check("pc clear sleep", {31'h0, clr_seen}, 32'h1);
        rd_chk("status sleep", `RSC_OFF_STATUS, 32'h3);
        low_power_mode <= 1'b0;
        tend("watchdog");
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        wait_core(1'b0);
        rd_chk("status por", `RSC_OFF_STATUS, 32'h0);
        rd_chk("cause por", `RSC_OFF_CAUSE, 32'h0);
        tend("second_power_on");
        test_done();
    end

    // hang guard, far beyond the few hundred cycles the tests take
    initial
    begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("FAIL watchdog expected end seen hang");
        test_done();
    end
endmodule // rsc_top_bench

`default_nettype wire
